// ---- include/uart_status_params.svh ----
/*
 * Offsets, field positions, reset values and codes of the baud, line status
 * and interrupt identification block. Assumes a 32-bit classic Wishbone bus.
 */
`ifndef UART_STATUS_PARAMS_SVH
`define UART_STATUS_PARAMS_SVH
// Word indices; byte address is four times the index
`define IDX_DATA_DIVLO 3'h0
`define IDX_IEN_DIVHI 3'h1
`define IDX_INT_ID 3'h2
`define IDX_LINE_CTRL 3'h3
`define IDX_LINE_STATUS 3'h5
// Line control field
`define LCR_DIV_ACCESS 7
// Line status fields
`define LSR_READY 0
`define LSR_OVERRUN 1
`define LSR_PARITY 2
`define LSR_FRAMING 3
`define LSR_BREAK 4
`define LSR_HOLD_EMPTY 5
`define LSR_SHIFT_EMPTY 6
// Interrupt enable inputs
`define IEN_RDA 0
`define IEN_TX_HOLDING_EMPTY 1
`define IEN_RLS 2
`define IEN_MODEM 3
// Source codes in identification bits 2:1
`define CODE_RLS 2'h3
`define CODE_RDA 2'h2
`define CODE_TX_HOLDING_EMPTY 2'h1
`define CODE_MODEM 2'h0
// Reset values
`define RST_DIV_BYTE 8'h00
`define RST_LINE_CTRL 8'h00
`define INT_ID_IDLE 8'h01
`endif

// ---- include/uart_status_pkg.sv ----
/*
 * Types of the baud, line status and interrupt identification block.
 * Assumes uart_status_params.svh is on the include path.
 */
`include "uart_status_params.svh"
package uart_status_pkg;
    // Interrupt sources as reported in identification bits 2:1
    typedef enum logic [1:0] {
        SRC_MODEM = `CODE_MODEM,
        SRC_TX_HOLDING_EMPTY = `CODE_TX_HOLDING_EMPTY,
        SRC_RDA = `CODE_RDA,
        SRC_RLS = `CODE_RLS
    } irq_src_t;

    // Complete state of the block
    typedef struct packed {
        logic [7:0] div_lo;      // Divisor low byte
        logic [7:0] div_hi;      // Divisor high byte
        logic [15:0] baud_cnt;   // Baud down-counter
        logic ref_q;             // Reference level last cycle
        logic tick;              // 16x tick pulse
        logic [7:0] line_ctrl;   // Line control byte
        logic ready;             // Received character waiting
        logic overrun;
        logic parity;
        logic framing;
        logic brk;
        logic hold_empty;
        logic shift_empty;
        logic tx_holding_empty_irq;          // Holding-empty interrupt pending
        logic frz_valid;         // Identification frozen
        irq_src_t frz_src;
        logic irq;
        logic ack;
        logic [31:0] dat;
        logic [7:0] host_byte;   // Last written byte to data or enable
        logic rbr_read;
        logic thr_write;
        logic ien_write;
    } state_t;
endpackage : uart_status_pkg

// ---- rtl/uart_baud_status.sv ----
/*
 * Baud divider, line status flags and prioritised interrupt identification
 * of an asynchronous serial element, as a classic Wishbone slave.
 * Assumes receiver, transmitter, enable and modem logic sit outside and
 * feed the strobes below synchronously to clk.
 */
// Chosen here: the placing of the registers and register access over Wishbone.
// Operation
// RULE1: Divide reference by 16-bit divisor, 16x tick
// RULE2: Divisor held in two 8-bit byte latches
// RULE3: Writing either latch reloads the down-counter
// RULE4: Reference kept within frequency limits externally
// RULE5: Software keeps data rate at most 56K
// RULE6: Ready flag sets on received character
// RULE7: Ready clears on buffer read or zero write
// RULE8: Overrun sets when unread character overwritten
// RULE9: Status read clears overrun flag
// RULE10: Parity flag sets on error, read clears
// RULE11: Framing flag sets on spacing stop bit
// RULE12: Break flag sets on long spacing input
// RULE13: Error flags raise line status interrupt
// RULE14: Holding-empty sets on transfer, clears on write
// RULE15: Shift-empty follows idle, clears on transfer
// RULE16: Status bit 7 always reads zero
// RULE17: Four fixed interrupt priority levels
// RULE18: Identification read freezes top pending source
// RULE19: Identification bit 0 low while pending
// RULE20: Bits 2:1 encode source, 7:3 zero
// RULE21: Divisor access bit selects divisor latches
// RULE22: Holding-empty interrupt cleared by read or write
// RULE23: Source codes 11,10,01,00; idle reads 0x01
// RULE24: Reset shows transmitter empty, flags clear
`timescale 1ns/10ps
`include "uart_status_params.svh"
// Register map, byte addresses, data in lane 0 of each word:
//   0x00 receive buffer read, holding write; divisor low with access set
//   0x04 enable read, enable write strobe; divisor high with access set
//   0x08 interrupt identification, read only
//   0x0c line control, read and write
//   0x14 line status; bits 0 to 5 writable so software can test interrupts
// Any other address is answered with zero and drops writes, so a stray
// access never hangs the host.
//
// A request is taken on the edge that sees cyc and stb with no answer
// pending; ack follows one cycle later and stands for exactly one cycle.
// Read data stands until the next read is taken.
//
// The reference is sampled by clk, so it must stay well below half the
// bus clock; each rising level counts one divider step. A zero divisor
// parks the divider rather than wrapping through 65536 steps.
//
// Hardware events win over host clears in the same cycle; otherwise an
// error arriving in the cycle of a status read would be lost unseen.
//
// The identification freeze holds until the shown source stops pending,
// so a handler keeps one stable code even when a higher source arrives.
module uart_baud_status (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic baud_ref_i,       // Reference clock level
    output logic baud_tick_o,          // One-cycle 16x tick
    input wire logic [7:0] rx_data_i,  // Receive buffer contents
    input wire logic rx_done_i,        // Character into receive buffer
    input wire logic rx_parity_err_i,
    input wire logic rx_framing_err_i,
    input wire logic rx_break_i,
    input wire logic tx_load_i,        // Holding to shift transfer
    input wire logic tx_idle_i,        // Shift register idle
    input wire logic [3:0] int_enable_i,
    input wire logic modem_pending_i,
    output logic [7:0] line_ctrl_o,
    output logic [15:0] divisor_o,
    output logic [7:0] host_byte_o,
    output logic rbr_read_o,
    output logic thr_write_o,
    output logic ien_write_o,
    output logic irq_out
);
    import uart_status_pkg::*;

    state_t s_q;
    state_t s_d;
    logic req;          // New bus request this cycle
    logic wr;           // Write of byte lane 0
    logic rd;
    logic [2:0] idx;
    logic mapped;
    logic div_access;
    logic [15:0] new_div;
    logic div_wr;
    logic ref_rise;
    logic [3:0] pend;   // RLS, RDA, TX_HOLDING_EMPTY, modem pending
    irq_src_t live_src;
    logic any_pend;
    logic [7:0] id_byte;
    logic [7:0] lsr_byte;
    logic [7:0] rd_byte;
    logic lsr_rd;
    logic id_rd;

    // Top pending source by fixed rank
    function automatic irq_src_t top_src(input logic [3:0] p);
        if (p[3]) begin
            return SRC_RLS; // RULE17
        end else if (p[2]) begin
            return SRC_RDA;
        end else if (p[1]) begin
            return SRC_TX_HOLDING_EMPTY;
        end
        return SRC_MODEM;
    endfunction : top_src

    // Source index into the pending vector
    function automatic logic still_pending(input logic [3:0] p, input irq_src_t s);
        unique case (s)
            SRC_RLS: return p[3];
            SRC_RDA: return p[2];
            SRC_TX_HOLDING_EMPTY: return p[1];
            SRC_MODEM: return p[0];
        endcase
    endfunction : still_pending

    // Decode and pending logic
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !s_q.ack;
        wr = req && wb_we_i && wb_sel_i[0];
        rd = req && !wb_we_i;
        idx = wb_adr_i[4:2];
        mapped = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0);
        div_access = s_q.line_ctrl[`LCR_DIV_ACCESS];
        lsr_rd = rd && mapped && (idx == `IDX_LINE_STATUS);
        id_rd = rd && mapped && (idx == `IDX_INT_ID);
        // Divisor latches only reachable with the access bit set
        div_wr = wr && mapped && div_access && // RULE21
            ((idx == `IDX_DATA_DIVLO) || (idx == `IDX_IEN_DIVHI));
        new_div = {s_q.div_hi, s_q.div_lo};
        if (idx == `IDX_DATA_DIVLO) begin
            new_div[7:0] = wb_dat_i[7:0]; // RULE2
        end else begin
            new_div[15:8] = wb_dat_i[7:0];
        end
        ref_rise = baud_ref_i && !s_q.ref_q;
        pend[3] = int_enable_i[`IEN_RLS] &&
            (s_q.overrun || s_q.parity || s_q.framing || s_q.brk); // RULE13
        pend[2] = int_enable_i[`IEN_RDA] && s_q.ready;
        pend[1] = int_enable_i[`IEN_TX_HOLDING_EMPTY] && s_q.tx_holding_empty_irq; // RULE14
        pend[0] = int_enable_i[`IEN_MODEM] && modem_pending_i;
        any_pend = |pend;
        live_src = top_src(pend);
        id_byte = `INT_ID_IDLE;
        // A frozen source is shown until it is serviced
        if (s_q.frz_valid && still_pending(pend, s_q.frz_src)) begin
            id_byte = {5'h00, s_q.frz_src, 1'b0}; // RULE18
        end else if (any_pend) begin
            id_byte = {5'h00, live_src, 1'b0}; // RULE19 RULE20 RULE23
        end
        // Status byte as the host reads it; bit 7 is tied low
        lsr_byte = {1'b0, s_q.shift_empty, s_q.hold_empty, s_q.brk, // RULE16
            s_q.framing, s_q.parity, s_q.overrun, s_q.ready};
        // Read multiplexer; the access bit swaps buffer and enables for the divisor
        rd_byte = 8'h00;
        if (mapped) begin
            unique case (idx)
                `IDX_DATA_DIVLO: rd_byte = div_access ? s_q.div_lo : rx_data_i;
                `IDX_IEN_DIVHI: rd_byte = div_access ? s_q.div_hi : {4'h0, int_enable_i};
                `IDX_INT_ID: rd_byte = id_byte;
                `IDX_LINE_CTRL: rd_byte = s_q.line_ctrl;
                `IDX_LINE_STATUS: rd_byte = lsr_byte;
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.rbr_read = 1'b0;
        s_d.thr_write = 1'b0;
        s_d.ien_write = 1'b0;
        s_d.ref_q = baud_ref_i;
        // Bus answer one cycle after the request, for one cycle
        s_d.ack = req;
        if (rd) begin
            s_d.dat = {24'h000000, rd_byte};
        end
        // Baud counter; a zero divisor stops the tick
        if (div_wr) begin
            s_d.baud_cnt = new_div; // RULE3
            if (idx == `IDX_DATA_DIVLO) begin
                s_d.div_lo = wb_dat_i[7:0];
            end else begin
                s_d.div_hi = wb_dat_i[7:0];
            end
        end else if (ref_rise && ({s_q.div_hi, s_q.div_lo} != 16'h0000)) begin
            if (s_q.baud_cnt <= 16'h0001) begin
                s_d.tick = 1'b1; // RULE1
                s_d.baud_cnt = {s_q.div_hi, s_q.div_lo};
            end else begin
                s_d.baud_cnt = s_q.baud_cnt - 16'h0001;
            end
        end
        // Register writes from the host
        if (wr && mapped) begin
            if (idx == `IDX_LINE_CTRL) begin
                s_d.line_ctrl = wb_dat_i[7:0];
            end
            if (!div_access && (idx == `IDX_DATA_DIVLO)) begin
                s_d.thr_write = 1'b1;
                s_d.host_byte = wb_dat_i[7:0];
                s_d.hold_empty = 1'b0; // RULE14
                s_d.tx_holding_empty_irq = 1'b0; // RULE22
            end
            if (!div_access && (idx == `IDX_IEN_DIVHI)) begin
                s_d.ien_write = 1'b1;
                s_d.host_byte = wb_dat_i[7:0];
            end
            // Low six status bits are writable for interrupt testing
            if (idx == `IDX_LINE_STATUS) begin
                s_d.ready = wb_dat_i[`LSR_READY]; // RULE7
                s_d.overrun = wb_dat_i[`LSR_OVERRUN];
                s_d.parity = wb_dat_i[`LSR_PARITY];
                s_d.framing = wb_dat_i[`LSR_FRAMING];
                s_d.brk = wb_dat_i[`LSR_BREAK];
                s_d.hold_empty = wb_dat_i[`LSR_HOLD_EMPTY];
                s_d.tx_holding_empty_irq = wb_dat_i[`LSR_HOLD_EMPTY];
            end
        end
        // Read side effects
        if (rd && mapped && !div_access && (idx == `IDX_DATA_DIVLO)) begin
            s_d.rbr_read = 1'b1;
            s_d.ready = 1'b0; // RULE7
        end
        if (lsr_rd) begin
            s_d.overrun = 1'b0; // RULE9
            s_d.parity = 1'b0; // RULE10
            s_d.framing = 1'b0;
            s_d.brk = 1'b0;
        end
        if (id_rd) begin
            s_d.frz_valid = any_pend || (id_byte[0] == 1'b0); // RULE18
            s_d.frz_src = irq_src_t'(id_byte[2:1]);
            if (id_byte[2:1] == `CODE_TX_HOLDING_EMPTY && !id_byte[0]) begin
                s_d.tx_holding_empty_irq = 1'b0; // RULE22
            end
        end else if (s_q.frz_valid && !still_pending(pend, s_q.frz_src)) begin
            s_d.frz_valid = 1'b0;
        end
        // Hardware events win over clears in the same cycle
        if (rx_done_i) begin
            // Unread character overwritten unless read in this cycle
            if (s_q.ready && !s_d.rbr_read) begin
                s_d.overrun = 1'b1; // RULE8
            end
            s_d.ready = 1'b1; // RULE6
        end
        if (rx_parity_err_i) begin
            s_d.parity = 1'b1; // RULE10
        end
        if (rx_framing_err_i) begin
            s_d.framing = 1'b1; // RULE11
        end
        if (rx_break_i) begin
            s_d.brk = 1'b1; // RULE12
        end
        if (tx_load_i) begin
            s_d.hold_empty = 1'b1; // RULE14
            s_d.tx_holding_empty_irq = 1'b1;
        end
        // Transfer takes the shifter out of idle at once
        s_d.shift_empty = tx_idle_i && !tx_load_i; // RULE15
        // Output lags the pending vector by one register, for a clean pin
        s_d.irq = any_pend;
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.div_lo <= `RST_DIV_BYTE;
            s_q.div_hi <= `RST_DIV_BYTE;
            s_q.line_ctrl <= `RST_LINE_CTRL;
            s_q.hold_empty <= 1'b1; // RULE24
            s_q.shift_empty <= 1'b1;
            s_q.frz_src <= SRC_MODEM;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state
    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign baud_tick_o = s_q.tick;
    assign line_ctrl_o = s_q.line_ctrl;
    assign divisor_o = {s_q.div_hi, s_q.div_lo};
    assign host_byte_o = s_q.host_byte;
    assign rbr_read_o = s_q.rbr_read;
    assign thr_write_o = s_q.thr_write;
    assign ien_write_o = s_q.ien_write;
    assign irq_out = s_q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Divisor write reloads the counter on the next edge
    div_reload_a: assert property (div_wr |=> s_q.baud_cnt == $past(new_div)) // RULE3
        else $error("divisor write did not reload counter");
    // Tick only on a reference edge with a nonzero divisor
    tick_cause_a: assert property (s_q.tick |-> $past(ref_rise) && divisor_o != 16'h0000) // RULE1
        else $error("baud tick without cause");
    // Ready follows a received character
    ready_set_a: assert property (rx_done_i |=> s_q.ready) // RULE6
        else $error("ready not set");
    overrun_set_a: assert property (rx_done_i && s_q.ready && !rbr_read_o && !(rd && mapped
        && !div_access && idx == `IDX_DATA_DIVLO) |=> s_q.overrun) // RULE8
        else $error("overrun not flagged");
    status_rdclr_a: assert property (lsr_rd && !rx_parity_err_i && !rx_done_i
        |=> !s_q.overrun && !s_q.parity) // RULE9
        else $error("status read did not clear errors");
    hold_empty_a: assert property (tx_load_i |=> s_q.hold_empty ##0 !s_q.shift_empty) // RULE14
        else $error("transfer flags wrong");
    id_idle_a: assert property (!any_pend && !s_q.frz_valid |-> id_byte == `INT_ID_IDLE) // RULE23
        else $error("idle identification wrong");
    id_rank_a: assert property (pend[3] && !s_q.frz_valid |-> id_byte[2:1] == `CODE_RLS) // RULE17
        else $error("line status not top");
    rls_irq_a: assert property (pend[3] |=> irq_out) // RULE13
        else $error("line status interrupt lost");
    bus_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
    // Identification bit 0 mirrors whether an enabled source is pending
    id_pend_a: assert property (id_byte[0] == !any_pend) // RULE19
        else $error("identification pending bit wrong");
    // Upper identification bits never carry anything
    id_zero_a: assert property (id_byte[7:3] == 5'h00) // RULE20
        else $error("identification upper bits not zero");
    // Status bit 7 is always zero
    lsr_top_a: assert property (lsr_byte[7] == 1'b0) // RULE16
        else $error("status bit 7 set");
    // A buffer read without a new character leaves ready clear
    ready_clr_a: assert property (rd && mapped && !div_access && // RULE7
        idx == `IDX_DATA_DIVLO && !rx_done_i |=> !s_q.ready)
        else $error("buffer read did not clear ready");
    // A holding write clears the empty flag and its request
    hold_clr_a: assert property (wr && mapped && !div_access && // RULE14
        idx == `IDX_DATA_DIVLO && !tx_load_i |=> !s_q.hold_empty && !s_q.tx_holding_empty_irq)
        else $error("holding write did not clear empty flag");
    // Reading the holding-empty code services that request
    tx_holding_empty_svc_a: assert property (id_rd && id_byte[2:1] == `CODE_TX_HOLDING_EMPTY && // RULE22
        !id_byte[0] && !tx_load_i |=> !s_q.tx_holding_empty_irq)
        else $error("identification read did not service holding empty");
    // Idle shifter shows empty one cycle later unless loaded
    shift_idle_a: assert property (tx_idle_i && !tx_load_i |=> s_q.shift_empty) // RULE15
        else $error("shift empty flag not set while idle");
    // A frozen source that still pends is what the host sees
    frozen_src_a: assert property (s_q.frz_valid && still_pending(pend, s_q.frz_src) // RULE18
        |-> id_byte[2:1] == s_q.frz_src)
        else $error("frozen source not shown");
    // Data and enable writes never touch the divisor
    div_guard_a: assert property (wr && mapped && !div_access |=> // RULE21
        divisor_o == $past(divisor_o))
        else $error("divisor changed without access bit");

    // Main scenarios worth seeing
    tick_seen_c: cover property (s_q.tick ##[1:300] s_q.tick);
    overrun_seen_c: cover property (s_q.overrun && irq_out);
    freeze_seen_c: cover property (id_rd && any_pend ##1 s_q.frz_valid);
    tx_holding_empty_clear_c: cover property (id_rd && id_byte[2:1] == `CODE_TX_HOLDING_EMPTY ##1 !s_q.tx_holding_empty_irq);
    ien_write_c: cover property (ien_write_o ##1 !ien_write_o);
endmodule : uart_baud_status

// ---- tb/test_uart_baud_status.sv ----
/*
 * Self-checking bench of the baud, status and identification block.
 * Assumes the design files and the host model are compiled first.
 */
`timescale 1ns/10ps
module test_uart_baud_status;
    logic clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, baud_ref_i, baud_tick_o, irq_out;
    logic rbr_read_o, thr_write_o, ien_write_o;
    logic [7:0] wb_adr, rx_data_i, line_ctrl_o, host_byte_o, v;
    logic [3:0] wb_sel, int_enable_i;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [4:0] ev;  // tx_load, break, framing, parity, done
    logic tx_idle_i, modem_pending_i;
    logic [15:0] divisor_o;
    int failures, checks, ticks, seed, i, rbr_n, thr_n, ien_n;

    uart_baud_status i_uart_baud_status (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .baud_ref_i(baud_ref_i),
        .baud_tick_o(baud_tick_o), .rx_data_i(rx_data_i), .rx_done_i(ev[0]),
        .rx_parity_err_i(ev[1]), .rx_framing_err_i(ev[2]), .rx_break_i(ev[3]),
        .tx_load_i(ev[4]), .tx_idle_i(tx_idle_i), .int_enable_i(int_enable_i),
        .modem_pending_i(modem_pending_i), .line_ctrl_o(line_ctrl_o), .divisor_o(divisor_o),
        .host_byte_o(host_byte_o), .rbr_read_o(rbr_read_o), .thr_write_o(thr_write_o),
        .ien_write_o(ien_write_o), .irq_out(irq_out));

    wb_host_model i_wb_host_model (.clk(clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
        .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w),
        .wb_dat_i(wb_dat_r), .wb_ack_i(wb_ack));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Tick counter for the divider checks, and cycles each access strobe stands
    always @(posedge clk) begin
        if (baud_tick_o === 1'b1) ticks++;
        if (rbr_read_o === 1'b1) rbr_n++;
        if (thr_write_o === 1'b1) thr_n++;
        if (ien_write_o === 1'b1) ien_n++;
    end

    // Expected ticks: a count of cnt runs down over n reference edges
    function automatic int ticks_for(input int cnt, input int dv, input int n);
        int t;
        t = 0;
        repeat (n) begin
            if (cnt <= 1) begin
                t++;
                cnt = dv;
            end else begin
                cnt--;
            end
        end
        return t;
    endfunction : ticks_for

    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask : chk

    // Bus access; a missing answer ends the run
    task automatic acc(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        logic ok;
        i_wb_host_model.access(we, adr, wd, v, ok);
        if (ok !== 1'b1) begin
            $display("ERROR bus answer expected 1 seen 0");
            failures++;
            complete_run();
        end
    endtask : acc

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp, input string name);
        acc(1'b0, adr, 8'h00);
        chk(name, {8'h00, exp}, {8'h00, v});
    endtask : rd

    // One-cycle receiver or transmitter strobes, then let flags settle
    task automatic fire(input logic [4:0] s);
        ev <= s;
        @(posedge clk);
        ev <= 5'h00;
        repeat (2) @(posedge clk);
    endtask : fire

    // Reference slow enough for small divisors and a rate under 56K
    task automatic ref_edges(input int n);
        repeat (n) begin
            baud_ref_i <= 1'b1;
            repeat (42) @(posedge clk);
            baud_ref_i <= 1'b0;
            repeat (42) @(posedge clk);
        end
    endtask : ref_edges

    initial begin
        {sys_rst, baud_ref_i, ev, modem_pending_i} = '0;
        {failures, checks, ticks, rbr_n, thr_n, ien_n} = '0;
        {rx_data_i, int_enable_i} = '0;
        tx_idle_i = 1'b1;
        seed = 54;
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(8'h14, 8'h60, "status at reset");
        rd(8'h08, 8'h01, "ident at reset");
        rd(8'h20, 8'h00, "unmapped");
        int_enable_i <= 4'h5;
        // Received bytes at random, read back through the buffer
        for (i = 0; i < 3; i++) begin
            rx_data_i <= 8'($random(seed));
            fire(5'h01);
            rd(8'h14, 8'h61, "status ready");
            rd(8'h08, 8'h04, "ident data");
            chk("irq", 16'h1, {15'h0, irq_out});
            rd(8'h00, rx_data_i, "rx byte");
            rd(8'h14, 8'h60, "status read clr");
        end
        fire(5'h01);
        fire(5'h01);
        rd(8'h08, 8'h06, "ident line");
        rd(8'h14, 8'h63, "status overrun");
        rd(8'h14, 8'h61, "status after");
        acc(1'b1, 8'h14, 8'h20);
        rd(8'h14, 8'h60, "status zero wr");
        rd(8'h08, 8'h01, "ident idle");
        for (i = 1; i < 4; i++) begin
            fire(5'(1 << i));
            rd(8'h08, 8'h06, "ident error");
            rd(8'h14, 8'(8'h60 | (1 << (i + 1))), "status error");
            rd(8'h14, 8'h60, "error clr");
        end
        // Enable write strobe with the access bit clear
        acc(1'b1, 8'h04, 8'h0f);
        chk("ien byte", 16'h000f, {8'h00, host_byte_o});
        chk("ien pulse", 16'h0001, 16'(ien_n));
        // Holding register write, transfer, and service by identification read
        int_enable_i <= 4'h7;
        acc(1'b1, 8'h00, 8'h5a);
        chk("host byte", 16'h005a, {8'h00, host_byte_o});
        chk("thr pulse", 16'h0001, 16'(thr_n));
        rd(8'h14, 8'h40, "status written");
        tx_idle_i <= 1'b0;
        fire(5'h10);
        rd(8'h14, 8'h20, "status loaded");
        rd(8'h08, 8'h02, "ident holding");
        rd(8'h08, 8'h01, "ident serviced");
        tx_idle_i <= 1'b1;
        // Frozen modem source hides a newer higher source
        int_enable_i <= 4'hf;
        modem_pending_i <= 1'b1;
        @(posedge clk);
        rd(8'h08, 8'h00, "ident modem");
        fire(5'h01);
        rd(8'h08, 8'h00, "ident frozen");
        modem_pending_i <= 1'b0;
        @(posedge clk);
        rd(8'h08, 8'h04, "ident released");
        rd(8'h00, rx_data_i, "rx drain");
        // Divisor of 3 through the access select bit
        acc(1'b1, 8'h0c, 8'h80);
        chk("line ctrl", 16'h0080, {8'h00, line_ctrl_o});
        acc(1'b1, 8'h00, 8'h03);
        acc(1'b1, 8'h04, 8'h00);
        chk("divisor", 16'h0003, divisor_o);
        rd(8'h00, 8'h03, "divisor low");
        ticks = 0;
        ref_edges(2);
        acc(1'b1, 8'h00, 8'h03);
        ref_edges(2);
        chk("ticks reload", 16'(ticks_for(3, 3, 2)), 16'(ticks));
        ref_edges(7);
        chk("ticks", 16'(ticks_for(1, 3, 7)), 16'(ticks));
        acc(1'b1, 8'h0c, 8'h00);
        chk("rbr pulses", 16'h0004, 16'(rbr_n));
        chk("thr pulses", 16'h0001, 16'(thr_n));
        chk("ien pulses", 16'h0001, 16'(ien_n));
        complete_run();
    end
endmodule : test_uart_baud_status

// ---- tb/wb_host_model.sv ----
/*
 * Host processor model: a classic Wishbone master with one access task.
 * Assumes the caller enters the task just after a rising clock edge.
 */
`timescale 1ns/10ps
module wb_host_model (
    input wire logic clk,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    // Idle bus at time zero; only byte lane 0 is ever used
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h1;
        wb_dat_o = 32'h00000000;
    end

    // One single cycle; ok stays low when no answer comes in time
    task automatic access(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                          output logic [7:0] rd, output logic ok);
        int n;
        n = 0;
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_sel_o <= 4'h1;
        wb_adr_o <= adr;
        wb_dat_o <= {24'h000000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 64);
        rd = wb_dat_i[7:0];
        ok = (wb_ack_i === 1'b1);
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // A released data bus must not look like it still holds the value
        wb_dat_o <= ~wb_dat_o;
        @(posedge clk);
    endtask : access
endmodule : wb_host_model
